// [rtl/mmdt_params.svh]
`ifndef MMDT_PARAMS_SVH
`define MMDT_PARAMS_SVH

// Time base tick period and clock rate
`define MMDT_CLK_HZ 25000000
`define MMDT_TICK_NS 1000000
`define MMDT_TICK_CYC ((`MMDT_TICK_NS) / (1000000000 / `MMDT_CLK_HZ))
// Default preset in ticks
`define MMDT_PRESET_DEF 32'h0000_03e8
// Count width
`define MMDT_CNT_W 32
// Mode codes as parameter values
`define MMDT_MODE_INTEG 2'h0
`define MMDT_MODE_ONESHOT 2'h1
`define MMDT_MODE_OFFDLY 2'h2
// Reset state of the output
`define MMDT_OUT_RST 1'b0

`endif

// [rtl/mmdt_pkg.sv]
package mmdt_pkg;
  typedef enum logic [1:0] {
    MMDT_IDLE,
    MMDT_TIMING,
    MMDT_HOLD,
    MMDT_DONE
  } mmdt_state_e;

  typedef struct packed {
    logic start;
    logic reset;
    logic enable;
  } mmdt_in_s;

  typedef struct packed {
    mmdt_state_e state;
    logic [31:0] count;
    logic out;
    logic busy;
    logic start_prev;
    logic reset_prev;
  } mmdt_core_s;

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } mmdt_tb_s;
endpackage : mmdt_pkg

// [rtl/mmdt_tick_gen.sv]
`timescale 1ns/1ns
`include "mmdt_params.svh"

module mmdt_tick_gen #(
  parameter logic [31:0] TICK_CYC = 32'(`MMDT_TICK_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic tick
);
  mmdt_pkg::mmdt_tb_s st_reg;
  mmdt_pkg::mmdt_tb_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.count = st_reg.count;
    end else if (st_reg.count >= TICK_CYC - 32'h1) begin
      st_next.count = 32'h0;
      st_next.tick = 1'b1;
    end else begin
      st_next.count = st_reg.count + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : mmdt_tick_gen

// [rtl/mmdt_timer.sv]
// Notes on behaviour
// RULE_01: Integration mode: count pauses, keeps its value, while enable is off.
// RULE_02: Integration mode: counting resumes from the kept value on re-enable.
// RULE_03: Integration mode: output on once summed intervals reach the preset.
// RULE_04: One-shot: output on at start, off after the preset elapses.
// RULE_05: One-shot: reset with start off during timing stops and clears output.
// RULE_06: One-shot: start ignored while an interval is running.
// RULE_07: OFF-delay: output on at start; held reset with start holds timing.
// RULE_08: OFF-delay: start sets output even if reset was already active.
// RULE_09: OFF-delay: preset count begins when reset is released.
// RULE_10: OFF-delay: output off once preset fully elapsed after release; the free-running time base can make the first tick partial.
// RULE_11: Outside contacts must be reliable; inputs carry a tiny current.
// RULE_12: Preset is a tick count; mode and preset fixed; reset clears all.
`timescale 1ns/1ns
`include "mmdt_params.svh"

module mmdt_timer #(
  parameter logic [1:0] MODE = `MMDT_MODE_INTEG,
  parameter logic [31:0] PRESET = `MMDT_PRESET_DEF,
  parameter logic [31:0] TICK_CYC = 32'(`MMDT_TICK_CYC)
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Contact inputs, active high, asynchronous
  input wire logic START_IN,
  input wire logic RESET_IN,
  input wire logic ENABLE_IN,
  // Control and busy outputs
  output logic CTRL_OUT,
  output logic BUSY_OUT
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  mmdt_pkg::mmdt_in_s sync1_reg;
  mmdt_pkg::mmdt_in_s sync2_reg;
  mmdt_pkg::mmdt_in_s in_s;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= '{start: START_IN, reset: RESET_IN, enable: ENABLE_IN};
      sync2_reg <= sync1_reg;
    end
  end

  assign in_s = sync2_reg;

  // ****************************************
  // Time base
  // ****************************************
  logic tick;
  logic tb_run;

  function automatic logic is_mode(input logic [1:0] m);
    is_mode = (MODE == m);
  endfunction : is_mode

  // Integration pauses the time base itself, so partial ticks are kept
  assign tb_run = is_mode(`MMDT_MODE_INTEG) ? in_s.enable : 1'b1; // [RULE_01]

  mmdt_tick_gen #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .run(tb_run),
    .tick(tick)
  );

  // ****************************************
  // Timer core
  // ****************************************
  mmdt_pkg::mmdt_core_s st_reg;
  mmdt_pkg::mmdt_core_s st_next;
  logic start_rise;
  logic reached;

  assign start_rise = in_s.start && !st_reg.start_prev;
  assign reached = (st_reg.count >= PRESET - 32'h1) && tick;

  always_comb begin
    st_next = st_reg;
    st_next.start_prev = in_s.start;
    st_next.reset_prev = in_s.reset;
    case (MODE)
      `MMDT_MODE_INTEG: begin
        case (st_reg.state)
          mmdt_pkg::MMDT_IDLE, mmdt_pkg::MMDT_TIMING: begin
            st_next.state = mmdt_pkg::MMDT_TIMING;
            // A tick only exists if it was earned while enabled
            if (tick) begin // [RULE_01] [RULE_02]
              st_next.count = st_reg.count + 32'h1;
              if (reached) begin
                st_next.state = mmdt_pkg::MMDT_DONE;
                st_next.out = 1'b1; // [RULE_03]
              end
            end
          end
          mmdt_pkg::MMDT_DONE: begin
            st_next.out = 1'b1;
          end
          default: begin
            st_next.state = mmdt_pkg::MMDT_IDLE;
          end
        endcase
      end
      `MMDT_MODE_ONESHOT: begin
        case (st_reg.state)
          mmdt_pkg::MMDT_IDLE: begin
            if (start_rise) begin
              st_next.state = mmdt_pkg::MMDT_TIMING;
              st_next.count = 32'h0;
              st_next.out = 1'b1; // [RULE_04]
            end
          end
          mmdt_pkg::MMDT_TIMING: begin
            // Start edges are not looked at here
            if (in_s.reset && !in_s.start) begin // [RULE_05] [RULE_06]
              st_next.state = mmdt_pkg::MMDT_IDLE;
              st_next.out = 1'b0;
              st_next.count = 32'h0;
            end else if (tick) begin
              st_next.count = st_reg.count + 32'h1;
              if (reached) begin
                st_next.state = mmdt_pkg::MMDT_IDLE;
                st_next.out = 1'b0; // [RULE_04]
              end
            end
          end
          default: begin
            st_next.state = mmdt_pkg::MMDT_IDLE;
            st_next.out = 1'b0;
          end
        endcase
      end
      `MMDT_MODE_OFFDLY: begin
        case (st_reg.state)
          mmdt_pkg::MMDT_IDLE: begin
            if (start_rise) begin // [RULE_08]
              st_next.out = 1'b1; // [RULE_07]
              st_next.count = 32'h0;
              st_next.state = in_s.reset ? mmdt_pkg::MMDT_HOLD
                                         : mmdt_pkg::MMDT_TIMING;
            end
          end
          mmdt_pkg::MMDT_HOLD: begin
            st_next.count = 32'h0;
            if (!in_s.reset) begin
              st_next.state = mmdt_pkg::MMDT_TIMING; // [RULE_09]
            end
          end
          mmdt_pkg::MMDT_TIMING: begin
            if (in_s.reset && in_s.start) begin
              st_next.state = mmdt_pkg::MMDT_HOLD; // [RULE_07]
              st_next.count = 32'h0;
            end else if (tick) begin
              st_next.count = st_reg.count + 32'h1;
              if (reached) begin
                st_next.state = mmdt_pkg::MMDT_IDLE;
                st_next.out = 1'b0; // [RULE_10]
              end
            end
          end
          default: begin
            st_next.state = mmdt_pkg::MMDT_IDLE;
            st_next.out = 1'b0;
          end
        endcase
      end
      default: begin
        st_next = st_reg;
      end
    endcase
    // Busy is registered alongside the state it reports
    st_next.busy = (st_next.state == mmdt_pkg::MMDT_TIMING);
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0; // [RULE_12]
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign CTRL_OUT = st_reg.out;
  assign BUSY_OUT = st_reg.busy;

  // ****************************************
  // Checks
  // ****************************************
  integ_hold_a: assert property ( // [RULE_01]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_INTEG) && !in_s.enable && !tick) |=>
      (st_reg.count == $past(st_reg.count)))
    else $error("count moved while paused");

  integ_out_a: assert property ( // [RULE_03]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_INTEG) && st_reg.out) |-> (st_reg.count >= PRESET))
    else $error("output before preset reached");

  one_start_a: assert property ( // [RULE_04]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_ONESHOT) && start_rise &&
     st_reg.state == mmdt_pkg::MMDT_IDLE) |=> st_reg.out)
    else $error("one-shot output not raised");

  one_reset_a: assert property ( // [RULE_05]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_ONESHOT) && st_reg.state == mmdt_pkg::MMDT_TIMING
     && in_s.reset && !in_s.start) |=> !st_reg.out)
    else $error("one-shot reset ignored");

  one_ignore_a: assert property ( // [RULE_06]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_ONESHOT) && st_reg.state == mmdt_pkg::MMDT_TIMING
     && start_rise && !in_s.reset && !tick) |=>
      (st_reg.count == $past(st_reg.count)))
    else $error("one-shot restarted");

  off_set_a: assert property ( // [RULE_08]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_OFFDLY) && start_rise &&
     st_reg.state == mmdt_pkg::MMDT_IDLE) |=> st_reg.out)
    else $error("off-delay output not raised");

  off_hold_a: assert property ( // [RULE_07]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_OFFDLY) && st_reg.state == mmdt_pkg::MMDT_HOLD)
      |-> (st_reg.out && st_reg.count == 32'h0))
    else $error("timing ran during hold");

  off_end_a: assert property ( // [RULE_10]
    @(posedge REF_CLK) disable iff (RST)
    (is_mode(`MMDT_MODE_OFFDLY) && $fell(st_reg.out)) |->
      (st_reg.count >= PRESET))
    else $error("off-delay ended early");
endmodule : mmdt_timer

// [tb/mmdt_contacts.sv]
`timescale 1ns/1ns

module mmdt_contacts (
  // Clock
  input wire logic clk,
  // Commanded contact state
  input wire mmdt_pkg::mmdt_in_s cmd,
  // Contact lines
  output logic start_in,
  output logic reset_in,
  output logic enable_in
);
  // ****
  // Clean, bounce-free contacts, one clock late
  // ****
  initial begin
    start_in = 1'b0;
    reset_in = 1'b0;
    enable_in = 1'b0;
  end

  always @(posedge clk) begin
    start_in <= cmd.start;
    reset_in <= cmd.reset;
    enable_in <= cmd.enable;
  end
endmodule : mmdt_contacts

// [tb/multi_mode_delay_timer_tb_top.sv]
`timescale 1ns/1ns

module multi_mode_delay_timer_tb_top;
  // ****
  // Signals
  // ****
  logic ref_clk;
  logic rst;
  mmdt_pkg::mmdt_in_s cmd;
  logic start_in;
  logic reset_in;
  logic enable_in;
  logic [2:0] ctrl;
  logic [2:0] busy;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  mmdt_contacts partner_u (
    .clk(ref_clk),
    .cmd(cmd),
    .start_in(start_in),
    .reset_in(reset_in),
    .enable_in(enable_in)
  );

  // One timer per mode, shared contacts
  for (genvar m = 0; m < 3; m++) begin : g_mode
    mmdt_timer #(
      .MODE(2'(m)),
      .PRESET(32'h0000_0004),
      .TICK_CYC(32'h0000_0003)
    ) dut_u (
      .REF_CLK(ref_clk),
      .RST(rst),
      .START_IN(start_in),
      .RESET_IN(reset_in),
      .ENABLE_IN(enable_in),
      .CTRL_OUT(ctrl[m]),
      .BUSY_OUT(busy[m])
    );
  end

  // ****
  // Helpers
  // ****
  task automatic final_report();
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk

  task automatic set_cmd(input logic s, input logic r, input logic e);
    @(posedge ref_clk);
    cmd <= '{start: s, reset: r, enable: e};
  endtask : set_cmd

  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : look

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      final_report();
    end
  end

  // ****
  // Scenarios
  // ****
  task automatic t_integ();
    set_cmd(1'b0, 1'b0, 1'b1);
    look(10);
    set_cmd(1'b0, 1'b0, 1'b0);
    look(30);
    chk(ctrl[0], 1'b0, "integ early");
    set_cmd(1'b0, 1'b0, 1'b1);
    look(12);
    chk(ctrl[0], 1'b1, "integ sum");
  endtask : t_integ

  task automatic t_shot();
    set_cmd(1'b1, 1'b0, 1'b0);
    look(5);
    chk(ctrl[1], 1'b1, "shot on");
    chk(busy[1], 1'b1, "shot busy");
    set_cmd(1'b0, 1'b0, 1'b0);
    set_cmd(1'b1, 1'b0, 1'b0);
    look(12);
    chk(ctrl[1], 1'b0, "shot off");
    chk(busy[1], 1'b0, "shot idle");
    set_cmd(1'b0, 1'b0, 1'b0);
    look(30);
  endtask : t_shot

  task automatic t_shot_reset();
    set_cmd(1'b1, 1'b0, 1'b0);
    set_cmd(1'b0, 1'b0, 1'b0);
    look(4);
    chk(ctrl[1], 1'b1, "shot on");
    set_cmd(1'b0, 1'b1, 1'b0);
    look(5);
    chk(ctrl[1], 1'b0, "shot reset");
    chk(busy[1], 1'b0, "shot reset busy");
    set_cmd(1'b0, 1'b0, 1'b0);
    look(30);
  endtask : t_shot_reset

  task automatic t_offdly();
    set_cmd(1'b0, 1'b1, 1'b0);
    look(4);
    set_cmd(1'b1, 1'b1, 1'b0);
    look(5);
    chk(ctrl[2], 1'b1, "off on");
    look(30);
    chk(ctrl[2], 1'b1, "off hold");
    set_cmd(1'b1, 1'b0, 1'b0);
    look(9);
    chk(ctrl[2], 1'b1, "off timing");
    look(10);
    chk(ctrl[2], 1'b0, "off done");
  endtask : t_offdly

  task automatic t_rst();
    @(posedge ref_clk);
    rst <= 1'b1;
    look(2);
    chk(|{ctrl, busy}, 1'b0, "mid-run reset outputs");
    @(posedge ref_clk);
    rst <= 1'b0;
    look(2);
  endtask : t_rst

  // ****
  // Main sequence
  // ****
  initial begin
    rst = 1'b1;
    cmd = '0;
    repeat (16) @(posedge ref_clk);
    #1;
    chk(|{ctrl, busy}, 1'b0, "reset outputs");
    @(posedge ref_clk);
    rst <= 1'b0;
    t_integ();
    t_shot();
    t_shot_reset();
    t_offdly();
    t_rst();
    final_report();
  end
endmodule : multi_mode_delay_timer_tb_top
